// ---- bfr_defines.svh ----
`ifndef BFR_DEFINES_SVH
`define BFR_DEFINES_SVH

// Widths
`define BFR_ADDR_W       23
`define BFR_DATA_W       16

// Register indices on the plain register port
`define BFR_CFG_IDX      4'h0
`define BFR_STAT_IDX     4'h1

// Configuration register field positions
`define BFR_MODE_BIT     15
`define BFR_LAT_HI       13
`define BFR_LAT_LO       11
`define BFR_POL_BIT      10
`define BFR_HOLD_BIT     9
`define BFR_TIMING_BIT   8
`define BFR_EDGE_BIT     6
`define BFR_WRAP_BIT     3
`define BFR_LEN_HI       2
`define BFR_LEN_LO       0
`define BFR_CFG_RESET    16'hBFCF

// Burst length and latency encodings
`define BFR_LEN_4        3'h1
`define BFR_LEN_8        3'h2
`define BFR_LEN_16       3'h3
`define BFR_LEN_CONT     3'h7
`define BFR_LAT_MIN      3'h2
`define BFR_WORDS_4      5'h04
`define BFR_WORDS_8      5'h08
`define BFR_WORDS_16     5'h10
`define BFR_BLK16_BITS   4

// Read spaces chosen by the last command
`define BFR_SPACE_ARRAY  2'h0
`define BFR_SPACE_STATUS 2'h1
`define BFR_SPACE_QUERY  2'h2
`define BFR_SPACE_IDENT  2'h3

// Timing
`define BFR_CLK_NS       5
`define BFR_T_STBY_NS    150
`define BFR_T_RAND_NS    80
`define BFR_T_PAGE_NS    25
`define BFR_PAGE_BITS    3

`endif

// ---- bfr_host_model.sv ----
`timescale 1ns/1ps

module bfr_host_model (
	// Clock
	input  wire logic        sys_clk,
	// Host bus pins
	output logic             ceN,
	output logic             oeN,
	output logic             latchEnN,
	output logic             busClk,
	output logic [22:0]      addrIn
);
	initial begin
		ceN = 1'b1;
		oeN = 1'b1;
		latchEnN = 1'b1;
		busClk = 1'b0;
		addrIn = '0;
	end

	// Asynchronous access, latch left transparent
	task automatic access(input logic [22:0] a);
		@(posedge sys_clk);
		ceN      <= 1'b0;
		oeN      <= 1'b0;
		latchEnN <= 1'b0;
		addrIn   <= a;
	endtask

	// Released address lines show the inverse of the last value
	task automatic idle();
		@(posedge sys_clk);
		ceN      <= 1'b1;
		oeN      <= 1'b1;
		latchEnN <= 1'b1;
		addrIn   <= ~addrIn;
	endtask

	// Burst of n clock periods, clock parked between frames; suspend before edge s
	task automatic burst(input logic [22:0] a, input int n, input int s, input logic rise);
		@(posedge sys_clk);
		busClk   <= ~rise;
		addrIn   <= a;
		ceN      <= 1'b0;
		oeN      <= 1'b0;
		latchEnN <= 1'b0;
		for (int e = 0; e < n; e++) begin
			repeat (16) @(posedge sys_clk);
			if (e == s) begin
				oeN <= 1'b1;
				repeat (40) @(posedge sys_clk);
				oeN <= 1'b0;
				repeat (8) @(posedge sys_clk);
			end
			busClk <= rise;
			repeat (16) @(posedge sys_clk);
			latchEnN <= 1'b1;
			busClk   <= ~rise;
		end
		repeat (16) @(posedge sys_clk);
		idle();
	endtask
endmodule

// ---- bfr_pkg.sv ----
`include "bfr_defines.svh"

package bfr_pkg;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_ASYNC = 5'h02,
		ST_ARMED = 5'h04,
		ST_LAT   = 5'h08,
		ST_DATA  = 5'h10
	} bfr_state_t;

	typedef struct packed {
		bfr_state_t                st;
		logic [15:0]               cfg;
		logic [15:0]               rdData;
		logic                      clkPrev;
		logic                      ceNPrev;
		logic                      oeNPrev;
		logic                      leNPrev;
		logic [`BFR_ADDR_W-1:0]    addrPrev;
		logic [`BFR_ADDR_W-1:0]    burstAddr;
		logic [`BFR_ADDR_W-1:0]    arrAddr;
		logic [`BFR_ADDR_W-1:0]    pageTag;
		logic                      pageValid;
		logic [4:0]                accLeft;
		logic [7:0]                idleCnt;
		logic [2:0]                latLeft;
		logic                      holdLeft;
		logic [4:0]                wordCnt;
		logic                      crossed;
		logic                      waitNow;
		logic                      waitSoon;
		logic                      ended;
		logic                      suspended;
		logic [`BFR_DATA_W-1:0]    dq;
		logic                      dqOe;
		logic                      waitOut;
		logic                      waitOe;
		logic                      standby;
	} bfr_regs_t;

endpackage

// ---- bfr_read_top.sv ----
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "bfr_defines.svh"

// What this block does
// R1: Mode bit one selects clock-ignoring asynchronous reads
// R2: Asynchronous data comes from command-selected space
// R3: Eight-word page, low three address bits
// R4: Page miss long access, hit short
// R5: Idle 150ns in asynchronous mode enters standby, outputs kept
// R6: Delay indicator deasserted in asynchronous mode
// R7: Host bursts only the array
// R8: Burst starts at edge after later fall
// R9: Address increments, words follow latency
// R10: Length field gives 4/8/16/continuous words
// R11: Hold bit keeps word one or two
// R12: Wrap confines addresses to aligned block
// R13: Indicator asserted in latency, waits, end
// R14: Continuous burst waits at first 16-crossing
// R15: Aligned start unaffected by wrap setting
// R16: Polarity bit sets indicator active level
// R17: Burst continues across bank boundaries
// R18: Host suspends via output enable, stopped clock
// R19: Suspend keeps data, may end latency
// R20: Resume continues at the stopped word
// R21: Indicator floats when enables are high
// R22: Single read repeats same word, same indicator
// R23: Latency codes two to seven, default seven
// R24: Edge bit picks falling or rising
// R25: Timing bit shifts indicator one cycle early
// R26: Host avoids latency-two early two-cycle combination
module bfr_read_top
	import bfr_pkg::*;
#(
	parameter int ADDR_W = `BFR_ADDR_W
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	// Host bus pins
	input  wire logic              ceN,
	input  wire logic              oeN,
	input  wire logic              latchEnN,
	input  wire logic              busClk,
	input  wire logic [ADDR_W-1:0] addrIn,
	// Command logic and data sources
	input  wire logic [1:0]        readSpace,
	input  wire logic [15:0]       arrayData,
	input  wire logic [15:0]       statusData,
	input  wire logic [15:0]       queryData,
	input  wire logic [15:0]       identData,
	output logic      [ADDR_W-1:0] arrAddr,
	// Data and delay indicator pins
	output logic      [15:0]       dqOut,
	output logic                   dqOe,
	output logic                   waitOut,
	output logic                   waitOe,
	output logic                   standby,
	// Register port
	input  wire logic [3:0]        regAddr,
	input  wire logic [15:0]       regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [15:0]       regRdData
);

	generate
		if (ADDR_W != `BFR_ADDR_W) begin : g_bad_width
			$error("ADDR_W must match the state record width");
		end
	endgenerate

	localparam logic [4:0] RAND_CYC = 5'((`BFR_T_RAND_NS + `BFR_CLK_NS - 1) / `BFR_CLK_NS);
	localparam logic [4:0] PAGE_CYC = 5'((`BFR_T_PAGE_NS + `BFR_CLK_NS - 1) / `BFR_CLK_NS);
	localparam logic [7:0] STBY_CYC = 8'((`BFR_T_STBY_NS + `BFR_CLK_NS - 1) / `BFR_CLK_NS);

	bfr_regs_t           s_q;
	bfr_regs_t           s_d;
	logic [3:0]          ctlS;
	logic [ADDR_W-1:0]   addrS;
	logic                ceNS;
	logic                oeNS;
	logic                leNS;
	logic                clkS;
	logic                asyncMode;
	logic [2:0]          latQ;
	logic                polQ;
	logic                holdQ;
	logic                earlyQ;
	logic                edgeQ;
	logic                wrapQ;
	logic [2:0]          lenQ;
	logic [4:0]          lenWords;
	logic [ADDR_W-1:0]   mask;
	logic [ADDR_W-1:0]   nxt;
	logic                edgeHit;
	logic                startDet;
	logic                addrChg;
	logic                pageHit;
	logic                arraySpace;
	logic [15:0]         srcData;
	logic                cfgLegal;
	logic                doPresent;
	logic                waitAct;

	bfr_sync2 #(.W(4), .INIT(4'hF)) u_sync_ctl (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.din     ({busClk, latchEnN, oeN, ceN}),
		.dout    (ctlS)
	);

	bfr_sync2 #(.W(ADDR_W), .INIT('0)) u_sync_addr (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.din     (addrIn),
		.dout    (addrS)
	);

	assign ceNS = ctlS[0];
	assign oeNS = ctlS[1];
	assign leNS = ctlS[2];
	assign clkS = ctlS[3];

	// Configuration fields
	assign asyncMode = s_q.cfg[`BFR_MODE_BIT];
	assign latQ      = s_q.cfg[`BFR_LAT_HI:`BFR_LAT_LO];
	assign polQ      = s_q.cfg[`BFR_POL_BIT];
	assign holdQ     = s_q.cfg[`BFR_HOLD_BIT];
	assign earlyQ    = s_q.cfg[`BFR_TIMING_BIT];
	assign edgeQ     = s_q.cfg[`BFR_EDGE_BIT];
	assign wrapQ     = !s_q.cfg[`BFR_WRAP_BIT];
	assign lenQ      = s_q.cfg[`BFR_LEN_HI:`BFR_LEN_LO];

	// Burst length in words, zero for continuous
	always_comb begin
		unique case (lenQ)
			`BFR_LEN_4:  lenWords = `BFR_WORDS_4;
			`BFR_LEN_8:  lenWords = `BFR_WORDS_8;
			`BFR_LEN_16: lenWords = `BFR_WORDS_16;
			default:     lenWords = 5'h00;
		endcase
	end

	assign mask = (lenWords == 5'h00) ? '0 : ADDR_W'(lenWords - 5'h01);

	// Next burst address: wrap keeps the aligned block, else plain increment across banks
	assign nxt = (wrapQ && lenWords != 5'h00) ? ((s_q.burstAddr & ~mask) | ((s_q.burstAddr + 1'b1) & mask)) // [R12] [R15]
	                                          : s_q.burstAddr + 1'b1; // [R17] [R9]

	// Valid clock edge on the sampled bus clock
	assign edgeHit  = edgeQ ? (clkS && !s_q.clkPrev) : (!clkS && s_q.clkPrev); // [R24]
	// Both enables low and one of them just fell
	assign startDet = !leNS && !ceNS && (s_q.leNPrev || s_q.ceNPrev); // [R8]
	assign addrChg  = addrS != s_q.addrPrev;
	assign pageHit  = s_q.pageValid && ((addrS >> `BFR_PAGE_BITS) == (s_q.pageTag >> `BFR_PAGE_BITS)); // [R3]
	assign arraySpace = readSpace == `BFR_SPACE_ARRAY;
	assign cfgLegal = (regWrData[`BFR_LAT_HI:`BFR_LAT_LO] >= `BFR_LAT_MIN)
	                  && (regWrData[`BFR_LEN_HI:`BFR_LEN_LO] inside {`BFR_LEN_4, `BFR_LEN_8, `BFR_LEN_16, `BFR_LEN_CONT}); // [R23]

	// Data of the space picked by the last command
	always_comb begin
		unique case (readSpace)
			`BFR_SPACE_ARRAY:  srcData = arrayData; // [R2]
			`BFR_SPACE_STATUS: srcData = statusData;
			`BFR_SPACE_QUERY:  srcData = queryData;
			default:           srcData = identData;
		endcase
	end

	always_comb begin
		s_d       = s_q;
		doPresent = 1'b0;
		waitAct   = 1'b0;
		s_d.rdData   = 16'h0000;
		s_d.clkPrev  = clkS;
		s_d.ceNPrev  = ceNS;
		s_d.oeNPrev  = oeNS;
		s_d.leNPrev  = leNS;
		s_d.addrPrev = addrS;

		// Bus inactivity timer for automatic standby; outputs stay driven
		if (addrChg || ceNS != s_q.ceNPrev || oeNS != s_q.oeNPrev || leNS != s_q.leNPrev) begin
			s_d.idleCnt = 8'h00;
			s_d.standby = 1'b0;
		end else if (s_q.idleCnt != STBY_CYC) begin
			s_d.idleCnt = s_q.idleCnt + 8'h01;
		end else if (asyncMode) begin
			s_d.standby = 1'b1; // [R5]
		end

		// Register port; reserved encodings leave the configuration untouched
		if (regWr && regAddr == `BFR_CFG_IDX && cfgLegal) begin
			s_d.cfg = regWrData;
		end
		if (regRd) begin
			unique case (regAddr)
				`BFR_CFG_IDX:  s_d.rdData = s_q.cfg;
				`BFR_STAT_IDX: s_d.rdData = {s_q.standby, s_q.suspended, s_q.ended, s_q.waitNow, 3'h0, s_q.st,
				                             s_q.holdLeft, 1'b0, s_q.wordCnt[1:0]};
				default:       s_d.rdData = 16'h0000;
			endcase
		end

		s_d.dqOe   = !ceNS && !oeNS;
		s_d.waitOe = !ceNS && !oeNS; // [R21]

		unique case (s_q.st)
			ST_IDLE: begin
				// Address and enable arrive together, so the first access starts here
				if (!ceNS && asyncMode) begin
					s_d.st        = ST_ASYNC;
					s_d.arrAddr   = addrS;
					s_d.pageTag   = addrS;
					s_d.pageValid = 1'b1;
					s_d.accLeft   = RAND_CYC; // [R4]
				end
			end
			ST_ASYNC: begin
				// Clock is ignored here
				if (ceNS || !asyncMode) begin
					s_d.st = ST_IDLE; // [R1]
				end else if (addrChg || s_q.ceNPrev) begin
					s_d.arrAddr   = addrS;
					s_d.pageTag   = addrS;
					s_d.pageValid = 1'b1;
					s_d.accLeft   = pageHit ? PAGE_CYC : RAND_CYC; // [R4]
				end else if (s_q.accLeft != 5'h00) begin
					s_d.accLeft = s_q.accLeft - 5'h01;
					if (s_q.accLeft == 5'h01) begin
						s_d.dq = srcData; // [R2]
					end
				end
			end
			ST_ARMED: begin
				if (edgeHit) begin
					s_d.burstAddr = addrS;
					s_d.arrAddr   = addrS;
					s_d.latLeft   = latQ; // [R23]
					s_d.wordCnt   = 5'h00;
					s_d.crossed   = addrS[`BFR_BLK16_BITS-1:0] == '0;
					s_d.ended     = 1'b0;
					s_d.waitNow   = 1'b0;
					s_d.waitSoon  = 1'b0;
					s_d.st        = ST_LAT;
				end
			end
			ST_LAT: begin
				if (oeNS) begin
					// Sensing finishes while suspended, so no latency is left
					s_d.suspended = 1'b1;
					s_d.latLeft   = 3'h1; // [R19]
				end else if (edgeHit) begin
					s_d.suspended = 1'b0;
					if (s_q.latLeft <= 3'h1) begin
						doPresent = 1'b1; // [R9]
					end else begin
						s_d.latLeft = s_q.latLeft - 3'h1;
					end
				end
			end
			ST_DATA: begin
				if (oeNS) begin
					s_d.suspended = 1'b1; // [R20]
				end else if (edgeHit) begin
					s_d.suspended = 1'b0;
					if (s_q.holdLeft) begin
						s_d.holdLeft = 1'b0; // [R11]
					end else if (s_q.ended) begin
						s_d.ended = 1'b1;
					end else if (lenWords != 5'h00 && s_q.wordCnt == lenWords) begin
						s_d.ended = 1'b1; // [R10]
					end else if (lenWords == 5'h00 && !s_q.crossed
					             && s_q.burstAddr[`BFR_BLK16_BITS-1:0] == '0) begin
						s_d.crossed = 1'b1;
						s_d.waitNow = 1'b1; // [R14]
					end else begin
						doPresent = 1'b1;
					end
				end
			end
			default: s_d.st = ST_IDLE;
		endcase

		// Presenting a word also prefetches the next address in the array space
		if (doPresent) begin
			s_d.st       = ST_DATA;
			s_d.dq       = srcData;
			s_d.holdLeft = holdQ; // [R11]
			s_d.wordCnt  = s_q.wordCnt + 5'h01;
			s_d.waitNow  = 1'b0;
			if (arraySpace) begin
				s_d.burstAddr = nxt; // [R9]
				s_d.arrAddr   = nxt;
			end
			// Non-array spaces keep the same word
			s_d.waitSoon = (lenWords != 5'h00 && s_q.wordCnt + 5'h01 == lenWords)
			               || (lenWords == 5'h00 && arraySpace && !s_q.crossed
			                   && nxt[`BFR_BLK16_BITS-1:0] == '0); // [R22]
		end

		// Synchronous start, and chip deselect ends any access
		if (!asyncMode && startDet) begin
			s_d.st        = ST_ARMED; // [R8]
			s_d.suspended = 1'b0;
		end else if (ceNS && s_q.st != ST_IDLE) begin
			s_d.st        = ST_IDLE;
			s_d.suspended = 1'b0;
		end

		// Delay indicator level
		if (asyncMode || s_d.st == ST_IDLE || s_d.st == ST_ASYNC) begin
			waitAct = 1'b0; // [R6]
		end else if (!earlyQ) begin
			waitAct = s_d.st == ST_ARMED || s_d.st == ST_LAT || s_d.waitNow || s_d.ended; // [R13]
		end else begin
			waitAct = s_d.st == ST_ARMED || (s_d.st == ST_LAT && s_d.latLeft != 3'h1)
			          || (s_d.st == ST_DATA && !s_d.holdLeft && s_d.waitSoon && !s_d.waitNow)
			          || s_d.ended; // [R25]
		end
		s_d.waitOut = polQ ? waitAct : !waitAct; // [R16]

		if (!reset_n) begin
			s_d           = '0;
			s_d.st        = ST_IDLE;
			s_d.cfg       = `BFR_CFG_RESET; // [R23] [R24] [R25]
			s_d.ceNPrev   = 1'b1;
			s_d.oeNPrev   = 1'b1;
			s_d.leNPrev   = 1'b1;
			s_d.clkPrev   = 1'b1;
			s_d.waitOut   = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		s_q <= s_d;
	end

	assign arrAddr   = s_q.arrAddr;
	assign dqOut     = s_q.dq;
	assign dqOe      = s_q.dqOe;
	assign waitOut   = s_q.waitOut;
	assign waitOe    = s_q.waitOe;
	assign standby   = s_q.standby;
	assign regRdData = s_q.rdData;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence seqArmEdge;
		s_q.st == ST_ARMED && edgeHit && !ceNS && !startDet;
	endsequence

	sequence seqSuspendData;
		oeNS && !ceNS && !startDet && s_q.st == ST_DATA;
	endsequence

	a_async_wait_off: assert property ( // [R6]
		s_q.st == ST_ASYNC && $stable(s_q.cfg) |-> s_q.waitOut == !polQ
	) else $error("delay indicator asserted in asynchronous mode");

	a_wait_float: assert property ( // [R21]
		ceNS || oeNS |=> !s_q.waitOe && !s_q.dqOe
	) else $error("delay indicator driven while deselected");

	a_page_short: assert property ( // [R4]
		s_q.st == ST_ASYNC && asyncMode && !ceNS && addrChg && pageHit |=> s_q.accLeft == PAGE_CYC
	) else $error("page hit did not use short access");

	a_page_long: assert property ( // [R4]
		s_q.st == ST_ASYNC && asyncMode && !ceNS && addrChg && !pageHit |=> s_q.accLeft == RAND_CYC
	) else $error("page miss did not use long access");

	a_standby_idle: assert property ( // [R5]
		s_q.standby |-> s_q.idleCnt == STBY_CYC
	) else $error("standby entered before bus idle time");

	a_start_arm: assert property ( // [R8]
		!asyncMode && startDet |=> s_q.st == ST_ARMED
	) else $error("burst start not armed");

	a_lat_load: assert property ( // [R23]
		seqArmEdge |=> s_q.st == ST_LAT && s_q.latLeft == $past(latQ)
	) else $error("latency not loaded from configuration");

	a_wrap_block: assert property ( // [R12]
		s_q.st == ST_DATA && wrapQ && lenWords != 5'h00 && $stable(s_q.cfg)
		|=> (s_q.burstAddr & ~mask) == ($past(s_q.burstAddr) & ~mask)
	) else $error("wrapped burst left its block");

	a_len_end: assert property ( // [R10]
		$rose(s_q.ended) && $stable(s_q.cfg) |-> lenWords != 5'h00 && s_q.wordCnt == lenWords
	) else $error("burst ended at wrong word count");

	a_cross_wait: assert property ( // [R14]
		$rose(s_q.waitNow) |-> lenWords == 5'h00 && s_q.burstAddr[`BFR_BLK16_BITS-1:0] == '0
	) else $error("wait state outside first boundary crossing");

	a_suspend_keep: assert property ( // [R20]
		seqSuspendData |=> $stable(s_q.dq) && $stable(s_q.burstAddr) && s_q.suspended
	) else $error("suspended burst lost its place");

	a_data_valid_wait: assert property ( // [R13]
		s_q.st == ST_DATA && !s_q.waitNow && !s_q.ended && !earlyQ && !asyncMode && $stable(s_q.cfg)
		|-> s_q.waitOut == !polQ
	) else $error("indicator asserted while data valid");

endmodule

// ---- bfr_read_top_tb.sv ----
`timescale 1ns/1ps
`include "bfr_defines.svh"

module bfr_read_top_tb
	import bfr_pkg::*;
;
	logic        sys_clk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0, rdPrev = 1'b0;
	logic        ceN, oeN, latchEnN, busClk, dqOe, waitOut, waitOe, standby;
	logic        inBurst = 1'b0, waitAct = 1'b1, actLvl = 1'b1;
	logic [22:0] addrIn, arrAddr, base;
	logic [15:0] arrayData, statusData, queryData, identData, dqOut, regRdData, key;
	logic [15:0] regWrData = '0, monD;
	logic [3:0]  regAddr = '0;
	logic [1:0]  readSpace = '0;
	int          failures = 0, compares = 0, cycles = 0, burstEdge = 0, monE;
	int          expE[$];
	logic [15:0] expD[$], rq[$];

	function automatic logic [15:0] fdat(input logic [22:0] a);
		return a[15:0] ^ {a[22:16], 9'h000} ^ key;
	endfunction

	function automatic logic [15:0] sdat(input logic [1:0] s);
		return ~key + 16'(s);
	endfunction

	assign arrayData  = fdat(arrAddr);
	assign statusData = sdat(2'h1);
	assign queryData  = sdat(2'h2);
	assign identData  = sdat(2'h3);

	bfr_read_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .ceN(ceN), .oeN(oeN), .latchEnN(latchEnN),
		.busClk(busClk), .addrIn(addrIn), .readSpace(readSpace), .arrayData(arrayData),
		.statusData(statusData), .queryData(queryData), .identData(identData), .arrAddr(arrAddr),
		.dqOut(dqOut), .dqOe(dqOe), .waitOut(waitOut), .waitOe(waitOe), .standby(standby),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

	bfr_host_model host_u (.sys_clk(sys_clk), .ceN(ceN), .oeN(oeN), .latchEnN(latchEnN),
		.busClk(busClk), .addrIn(addrIn));

	always #2.5 sys_clk = ~sys_clk;

	task automatic results();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One strobe cycle; for reads d is the expected answer
	task automatic regOp(input logic wr, input logic [3:0] idx, input logic [15:0] d);
		@(posedge sys_clk);
		regWr     <= wr;
		regRd     <= !wr;
		regAddr   <= idx;
		regWrData <= d;
		if (!wr)
			rq.push_back(d);
	endtask

	task automatic regIdle();
		@(posedge sys_clk);
		regWr <= 1'b0;
		regRd <= 1'b0;
	endtask

	// Read answer stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rdPrev)
			chk(regRdData, rq.size() ? rq.pop_front() : 16'hXXXX);
		rdPrev <= regRd;
	end

	// Sample at each active bus edge with the indicator inactive the word launched by the previous one
	always @(busClk) begin
		if (inBurst && busClk === actLvl) begin
			if (burstEdge > 0 && waitOut !== waitAct) begin
				monE = expE.size() ? expE.pop_front() : -1;
				monD = expD.size() ? expD.pop_front() : 16'hXXXX;
				chk({16'(burstEdge - 1), dqOut}, {16'(monE), monD});
			end
			burstEdge++;
		end
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			results();
		end
	end

	// Expected edge and word for every data cycle, then the burst itself
	task automatic row(input logic [2:0] lat, input logic hold, pol, rise, nowrap, input logic [2:0] len,
		input logic [22:0] a, input int n, s, input logic [1:0] sp);
		int w, ed;
		logic [22:0] ad;
		w = (len == `BFR_LEN_CONT) ? 0 : (2 << len);
		regOp(1'b1, `BFR_CFG_IDX, {2'b00, lat, pol, hold, 1'b0, 1'b1, rise, 2'b00, nowrap, len});
		regIdle();
		readSpace <= sp;
		for (int k = 0; w == 0 || k < w; k++) begin
			ad = (!nowrap && w != 0) ? ((a & ~23'(w - 1)) | ((a + 23'(k)) & 23'(w - 1))) : a + 23'(k);
			ed = lat + k * (hold + 1) + ((w == 0 && a[3:0] != 0 && a[3:0] + k >= 16) ? 1 : 0);
			if (ed + hold > n - 2)
				break;
			for (int h = 0; h <= hold; h++) begin
				expE.push_back(ed + h);
				expD.push_back(sp == 0 ? fdat(ad) : sdat(sp));
			end
		end
		waitAct   = pol;
		actLvl    = rise;
		burstEdge = 0;
		inBurst   = 1'b1;
		host_u.burst(a, n, s, rise);
		inBurst = 1'b0;
		chk(expE.size(), 0);
		repeat (6) @(posedge sys_clk);
		chk({dqOe, waitOe}, 0);
	endtask

	initial begin
		void'($urandom(32'hA01D));
		key  = 16'($urandom);
		base = 23'($urandom) & 23'h7FFFC0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		regOp(1'b0, `BFR_CFG_IDX, `BFR_CFG_RESET);
		regOp(1'b1, `BFR_CFG_IDX, 16'h0BCF);
		regOp(1'b0, `BFR_CFG_IDX, `BFR_CFG_RESET);
		regOp(1'b0, 4'h7, 16'h0000);
		regIdle();
		for (int s = 0; s < 4; s++) begin
			readSpace <= 2'(s);
			host_u.access(base + 23'(s * 8));
			repeat (40) @(posedge sys_clk);
			chk(dqOut, s == 0 ? fdat(base) : sdat(2'(s)));
		end
		readSpace <= 2'h0;
		host_u.access(base + 23'h30);
		repeat (40) @(posedge sys_clk);
		host_u.access(base + 23'h35);
		repeat (12) @(posedge sys_clk);
		chk(dqOut, fdat(base + 23'h35));
		host_u.access(base + 23'h38);
		repeat (12) @(posedge sys_clk);
		chk(dqOut, fdat(base + 23'h35));
		repeat (30) @(posedge sys_clk);
		chk(dqOut, fdat(base + 23'h38));
		repeat (40) @(posedge sys_clk);
		chk({standby, dqOe, waitOut}, 3'b110);
		host_u.idle();
		row(3'h3, 1'b0, 1'b1, 1'b1, 1'b0, `BFR_LEN_4, base | 23'h2, 10, -1, 2'h0);
		row(3'h5, 1'b1, 1'b0, 1'b1, 1'b1, `BFR_LEN_8, 23'h07FFFE, 24, -1, 2'h0);
		row(`BFR_LAT_MIN, 1'b0, 1'b1, 1'b0, 1'b0, `BFR_LEN_16, base, 20, -1, 2'h0);
		row(3'h7, 1'b0, 1'b1, 1'b1, 1'b0, `BFR_LEN_CONT, base | 23'hE, 16, 10, 2'h0);
		row(3'h4, 1'b0, 1'b1, 1'b1, 1'b0, `BFR_LEN_4, base, 10, -1, 2'h1);
		results();
	end
endmodule

// ---- bfr_sync2.sv ----
`timescale 1ns/1ps

module bfr_sync2 #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	// Asynchronous level in, synchronised level out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] stage1_q;
	logic [W-1:0] stage2_q;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			stage1_q <= INIT;
			stage2_q <= INIT;
		end else begin
			stage1_q <= din;
			stage2_q <= stage1_q;
		end
	end

	assign dout = stage2_q;

endmodule
